/* File: logic/sacc_top.sv */
// Conversion control for a 12-bit SAR converter and its high-voltage amplifier.
// Assumes timer overflows are one-cycle pulses on ref_clk and that the
// external start pin and the window comparator are asynchronous or same-clock
// as noted at the ports.
//
// Functional notes
// - Bit 7 of amplifier control enables the high-voltage amplifier.
// - Four-bit amplifier gain code is held and driven to the analog stage.
// - SAR clock is system clock divided by divider field plus one.
// - Three-bit PGA code decodes to gains 1,2,4,8,16,16,0.5,0.5.
// - Converter enable bit powers the converter; zero means shutdown.
// - Two-bit start source picks software, timer three, pin edge, timer two.
// - Writing busy one starts only with software source; writing zero does nothing.
// - Busy reads one throughout a conversion and zero afterwards.
// - Busy falling at the end of a conversion sets the done flag and pulses the interrupt request.
// - Done flag stays set until software writes zero to it.
// - Window match sets its flag, held until software clears it.
// - Each finished conversion lands in the result byte pair.
// - Justify bit selects right or left alignment of the result.
// - Right: high nibble sign or zero; left: low nibble reads zero.
// - Track-mode zero tracks continuously whenever enabled and idle.
// - Low-power mode with internal start tracks three SAR clocks first.
// - Low-power mode with pin start tracks while low, converts on rise.
// - Tracking is suspended while the chip is in standby.
//
// The plain strobed port was left to the implementer.
`include "sacc_map.svh"
`default_nettype none

module sacc_top #(
  parameter int RESULT_BITS = 12,
  parameter int DIV_BITS = 5
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // Register port.
  input wire logic [7:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_we,
  input wire logic bus_re,
  output logic [7:0] bus_rdata_q,
  // Start triggers; the pin is asynchronous, the timers are on ref_clk.
  input wire logic timer2_overflow,
  input wire logic timer3_overflow,
  input wire logic ext_convert_start,
  // Chip state and analog core results, all on ref_clk.
  input wire logic chip_standby,
  input wire logic window_match,
  input wire logic [11:0] sar_result,
  input wire logic sar_differential,
  // Analog core controls and events.
  output sacc_pkg::sacc_afe_t afe_q,
  output logic sar_clock_q,
  output logic conversion_done_pulse_q
);
  import sacc_pkg::*;

  localparam logic [4:0] CONV_CLOCKS = 5'(RESULT_BITS + `SACC_CONV_OVERHEAD);

  // The result layout in the byte pair is fixed to twelve bits.
  if (RESULT_BITS != 12) begin : g_bad_bits
    $error("sacc_top serves a 12-bit result only");
  end
  if (DIV_BITS != 5) begin : g_bad_div
    $error("sacc_top serves a 5-bit divider field only");
  end

  logic [7:0] cfg_q;
  logic hva_en_q;
  logic [3:0] hva_gain_q;
  sacc_ctrl_t ctrl_q;
  sacc_ctrl_t ctrl_eff;
  logic done_q;
  logic win_q;
  logic [11:0] res_q;
  logic diff_q;
  sacc_state_t state_q;
  logic [DIV_BITS-1:0] div_cnt_q;
  logic [1:0] trk_cnt_q;
  logic [4:0] conv_cnt_q;
  logic [4:0] conv_age_q;
  logic ext_s1_q;
  logic ext_s2_q;
  logic ext_s3_q;
  logic ext_q;
  logic ext_prev_q;
  logic ext_rise;
  logic wr_cfg;
  logic wr_hva;
  logic wr_ctrl;
  logic sw_start;
  logic start_evt;
  logic sar_tick;
  logic conv_end;
  logic busy;
  logic [DIV_BITS-1:0] div_field;

  assign wr_cfg = bus_we && (bus_addr == `SACC_ADDR_CFG);
  assign wr_hva = bus_we && (bus_addr == `SACC_ADDR_HVA);
  assign wr_ctrl = bus_we && (bus_addr == `SACC_ADDR_CTRL);
  assign div_field = cfg_q[`SACC_CFG_DIV_HI:`SACC_CFG_DIV_LO];
  assign busy = (state_q != SACC_ST_IDLE);

  // A control write takes effect in its own cycle so that one write can both
  // enable the converter and start it.
  always_comb begin
    ctrl_eff = ctrl_q;
    if (wr_ctrl) begin
      ctrl_eff.en = bus_wdata[`SACC_CTRL_EN];
      ctrl_eff.tm = bus_wdata[`SACC_CTRL_TM];
      ctrl_eff.src = sacc_src_t'(bus_wdata[`SACC_CTRL_CM_HI:`SACC_CTRL_CM_LO]);
      ctrl_eff.ljst = bus_wdata[`SACC_CTRL_LJST];
    end
  end

  // Configuration and amplifier registers.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cfg_q <= `SACC_CFG_RST;
      hva_en_q <= 1'(`SACC_HVA_RST >> `SACC_HVA_EN);
      hva_gain_q <= 4'h0;
    end else begin
      if (wr_cfg) begin
        cfg_q <= bus_wdata;
      end
      if (wr_hva) begin
        hva_en_q <= bus_wdata[`SACC_HVA_EN];
        hva_gain_q <= bus_wdata[`SACC_HVA_GAIN_HI:`SACC_HVA_GAIN_LO];
      end
    end
  end

  // Control register fields.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= '0;
    end else begin
      ctrl_q <= ctrl_eff;
    end
  end

  // Sticky flags: a hardware set in the cycle of a clearing write wins.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      done_q <= 1'b0;
      win_q <= 1'b0;
    end else begin
      if (conv_end) begin
        done_q <= 1'b1;
      end else if (wr_ctrl && !bus_wdata[`SACC_CTRL_DONE]) begin
        done_q <= 1'b0;
      end
      if (window_match) begin
        win_q <= 1'b1;
      end else if (wr_ctrl && !bus_wdata[`SACC_CTRL_WIN]) begin
        win_q <= 1'b0;
      end
    end
  end

  // External start pin: a level counts once the second and third stages agree.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
      ext_q <= 1'b0;
      ext_prev_q <= 1'b0;
    end else begin
      ext_s1_q <= ext_convert_start;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
      if (ext_s2_q == ext_s3_q) begin
        ext_q <= ext_s2_q;
      end
      ext_prev_q <= ext_q;
    end
  end

  assign ext_rise = ext_q && !ext_prev_q;

  // Start source selection.
  always_comb begin
    sw_start = wr_ctrl && bus_wdata[`SACC_CTRL_BUSY] && (ctrl_eff.src == SACC_SRC_SW);
    case (ctrl_eff.src)
      SACC_SRC_SW: start_evt = sw_start;
      SACC_SRC_TMR3: start_evt = timer3_overflow;
      SACC_SRC_EXT: start_evt = ext_rise;
      default: start_evt = timer2_overflow;
    endcase
  end

  // The SAR divider only runs while a sequence is active, so each tracking
  // and conversion period is a whole number of SAR clocks.
  assign sar_tick = busy && (div_cnt_q == '0);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      div_cnt_q <= '0;
    end else if (!busy || sar_tick) begin
      div_cnt_q <= div_field;
    end else begin
      div_cnt_q <= div_cnt_q - 1'b1;
    end
  end

  assign conv_end = (state_q == SACC_ST_CONV) && sar_tick && ctrl_eff.en &&
                    (conv_cnt_q == CONV_CLOCKS - 5'h1);

  // Sequence state machine.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_q <= SACC_ST_IDLE;
    end else if (!ctrl_eff.en) begin
      state_q <= SACC_ST_IDLE;
    end else begin
      case (state_q)
        SACC_ST_IDLE: begin
          if (start_evt) begin
            if (ctrl_eff.tm && ctrl_eff.src != SACC_SRC_EXT) begin
              state_q <= SACC_ST_TRACK;
            end else begin
              state_q <= SACC_ST_CONV;
            end
          end
        end
        SACC_ST_TRACK: begin
          if (sar_tick && trk_cnt_q == `SACC_TRACK_CLOCKS - 2'd1) begin
            state_q <= SACC_ST_CONV;
          end
        end
        SACC_ST_CONV: begin
          if (conv_end) begin
            state_q <= SACC_ST_IDLE;
          end
        end
        default: state_q <= SACC_ST_IDLE;
      endcase
    end
  end

  // SAR clock counters for tracking and conversion.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      trk_cnt_q <= 2'h0;
      conv_cnt_q <= 5'h0;
    end else if (state_q == SACC_ST_IDLE) begin
      trk_cnt_q <= 2'h0;
      conv_cnt_q <= 5'h0;
    end else if (sar_tick) begin
      if (state_q == SACC_ST_TRACK) begin
        trk_cnt_q <= trk_cnt_q + 2'h1;
      end else begin
        conv_cnt_q <= conv_cnt_q + 5'h1;
      end
    end
  end

  // Result capture at the end of each conversion.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      res_q <= 12'h000;
      diff_q <= 1'b0;
    end else if (conv_end) begin
      res_q <= sar_result;
      diff_q <= sar_differential;
    end
  end

  // Analog controls; these lag the state by one cycle.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      afe_q <= '0;
      sar_clock_q <= 1'b0;
      conversion_done_pulse_q <= 1'b0;
    end else begin
      afe_q.hv_amp_enable <= hva_en_q;
      afe_q.hv_amp_gain_code <= hva_gain_q;
      case (cfg_q[`SACC_CFG_PGA_HI:`SACC_CFG_PGA_LO])
        3'h0: afe_q.pga_gain <= SACC_PGA_X1;
        3'h1: afe_q.pga_gain <= SACC_PGA_X2;
        3'h2: afe_q.pga_gain <= SACC_PGA_X4;
        3'h3: afe_q.pga_gain <= SACC_PGA_X8;
        3'h4, 3'h5: afe_q.pga_gain <= SACC_PGA_X16;
        default: afe_q.pga_gain <= SACC_PGA_X0P5;
      endcase
      afe_q.converter_enable <= ctrl_q.en;
      // Standby suspends every form of tracking to save the sample current.
      afe_q.track <= ctrl_q.en && !chip_standby &&
                     ((!ctrl_q.tm && !busy) ||
                      (ctrl_q.tm && state_q == SACC_ST_TRACK) ||
                      (ctrl_q.tm && ctrl_q.src == SACC_SRC_EXT && !busy && !ext_q));
      afe_q.convert_active <= (state_q == SACC_ST_CONV);
      sar_clock_q <= sar_tick;
      conversion_done_pulse_q <= conv_end;
    end
  end

  // Register reads: data stand for one cycle, unmapped offsets read zero.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bus_rdata_q <= 8'h00;
    end else if (!bus_re) begin
      bus_rdata_q <= 8'h00;
    end else if (bus_addr == `SACC_ADDR_CFG) begin
      bus_rdata_q <= cfg_q;
    end else if (bus_addr == `SACC_ADDR_HVA) begin
      bus_rdata_q <= {hva_en_q, 3'h0, hva_gain_q};
    end else if (bus_addr == `SACC_ADDR_CTRL) begin
      bus_rdata_q <= {ctrl_q.en, ctrl_q.tm, done_q, busy, ctrl_q.src, win_q, ctrl_q.ljst};
    end else if (bus_addr == `SACC_ADDR_RES_HI) begin
      if (ctrl_q.ljst) begin
        bus_rdata_q <= res_q[11:4];
      end else begin
        bus_rdata_q <= {{4{diff_q & res_q[11]}}, res_q[11:8]};
      end
    end else if (bus_addr == `SACC_ADDR_RES_LO) begin
      if (ctrl_q.ljst) begin
        bus_rdata_q <= {res_q[3:0], 4'h0};
      end else begin
        bus_rdata_q <= res_q[7:0];
      end
    end else begin
      bus_rdata_q <= 8'h00;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      conv_age_q <= 5'h0;
    end else begin
      conv_age_q <= (state_q != SACC_ST_CONV) ? 5'h0 : conv_age_q + 5'h1;
    end
  end

  a_done_on_fall: assert property (@(posedge ref_clk) disable iff (rst)
    (busy && ctrl_eff.en && state_q == SACC_ST_CONV && conv_end) |=>
      (!busy && done_q && conversion_done_pulse_q))
    else $error("done flag not set when busy fell");

  a_done_sticky: assert property (@(posedge ref_clk) disable iff (rst)
    (done_q && !(wr_ctrl && !bus_wdata[`SACC_CTRL_DONE])) |=> done_q)
    else $error("done flag cleared without a software write");

  a_window_flag: assert property (@(posedge ref_clk) disable iff (rst)
    window_match |=> win_q)
    else $error("window flag not set on match");

  a_ignore_disabled: assert property (@(posedge ref_clk) disable iff (rst)
    (!ctrl_eff.en) |=> (state_q == SACC_ST_IDLE))
    else $error("sequence running while disabled");

  a_sw_start_mode: assert property (@(posedge ref_clk) disable iff (rst)
    (!busy && wr_ctrl && bus_wdata[`SACC_CTRL_EN] && bus_wdata[`SACC_CTRL_BUSY] &&
     bus_wdata[`SACC_CTRL_CM_HI:`SACC_CTRL_CM_LO] != 2'h0 &&
     bus_wdata[`SACC_CTRL_CM_HI:`SACC_CTRL_CM_LO] != 2'h1 &&
     bus_wdata[`SACC_CTRL_CM_HI:`SACC_CTRL_CM_LO] != 2'h3 && !ext_rise) |=> !busy)
    else $error("busy write started a conversion outside software mode");

  a_track_three: assert property (@(posedge ref_clk) disable iff (rst)
    ($rose(state_q == SACC_ST_TRACK) && div_field == 5'h0 && ctrl_q.en)
      |-> (state_q == SACC_ST_TRACK) [*3] ##1 (state_q == SACC_ST_CONV || !ctrl_q.en))
    else $error("low-power tracking did not last three SAR clocks");

  a_div_period: assert property (@(posedge ref_clk) disable iff (rst)
    (sar_tick && div_field == 5'h1 && state_q == SACC_ST_CONV && !conv_end)
      |=> !sar_tick ##1 (sar_tick || !busy))
    else $error("SAR clock period does not follow the divider");

  a_conv_length: assert property (@(posedge ref_clk) disable iff (rst)
    ($past(state_q == SACC_ST_CONV && ctrl_eff.en) && div_field == 5'h0) |->
      (($past(conv_age_q) < CONV_CLOCKS - 5'h1) == (state_q == SACC_ST_CONV)))
    else $error("conversion did not take fourteen SAR clocks");

  a_busy_read: assert property (@(posedge ref_clk) disable iff (rst)
    (bus_re && bus_addr == `SACC_ADDR_CTRL) |=>
      (bus_rdata_q[`SACC_CTRL_BUSY] == $past(busy)))
    else $error("busy bit misreported");

  a_right_just: assert property (@(posedge ref_clk) disable iff (rst)
    (bus_re && bus_addr == `SACC_ADDR_RES_HI && !ctrl_q.ljst && !diff_q) |=>
      (bus_rdata_q[7:4] == 4'h0))
    else $error("single-ended right-justified high nibble not zero");

  a_left_just: assert property (@(posedge ref_clk) disable iff (rst)
    (bus_re && bus_addr == `SACC_ADDR_RES_LO && ctrl_q.ljst) |=>
      (bus_rdata_q[3:0] == 4'h0 && bus_rdata_q[7:4] == $past(res_q[3:0])))
    else $error("left-justified low byte wrong");

  a_cont_track: assert property (@(posedge ref_clk) disable iff (rst)
    (ctrl_q.en && !ctrl_q.tm && !busy && !chip_standby) |=> afe_q.track)
    else $error("continuous tracking not active while idle");

endmodule

`default_nettype wire

/* File: shared/sacc_map.svh */
// Register offsets, field positions, reset values and timing counts
// of the converter control block.
// Assumes an 8-bit register port addressed by the printed offsets.
`ifndef SACC_MAP_SVH
`define SACC_MAP_SVH

`define SACC_ADDR_CFG 8'hbc
`define SACC_ADDR_HVA 8'hd6
`define SACC_ADDR_CTRL 8'he8
`define SACC_ADDR_RES_HI 8'hbf
`define SACC_ADDR_RES_LO 8'hbe

`define SACC_CFG_RST 8'hf8
`define SACC_HVA_RST 8'h00
`define SACC_CTRL_RST 8'h00

`define SACC_CTRL_EN 7
`define SACC_CTRL_TM 6
`define SACC_CTRL_DONE 5
`define SACC_CTRL_BUSY 4
`define SACC_CTRL_CM_HI 3
`define SACC_CTRL_CM_LO 2
`define SACC_CTRL_WIN 1
`define SACC_CTRL_LJST 0

`define SACC_CFG_DIV_HI 7
`define SACC_CFG_DIV_LO 3
`define SACC_CFG_PGA_HI 2
`define SACC_CFG_PGA_LO 0

`define SACC_HVA_EN 7
`define SACC_HVA_GAIN_HI 3
`define SACC_HVA_GAIN_LO 0

`define SACC_TRACK_CLOCKS 2'd3
`define SACC_CONV_OVERHEAD 2

`endif

/* File: shared/sacc_pkg.sv */
// Types shared by the converter control block and its bench.
// Assumes the constants of sacc_map.svh for the register layout.
`default_nettype none

package sacc_pkg;

  typedef enum logic [1:0] {
    SACC_SRC_SW = 2'h0,
    SACC_SRC_TMR3 = 2'h1,
    SACC_SRC_EXT = 2'h2,
    SACC_SRC_TMR2 = 2'h3
  } sacc_src_t;

  typedef enum logic [1:0] {
    SACC_ST_IDLE = 2'h0,
    SACC_ST_TRACK = 2'h1,
    SACC_ST_CONV = 2'h3
  } sacc_state_t;

  typedef enum logic [2:0] {
    SACC_PGA_X1 = 3'h0,
    SACC_PGA_X2 = 3'h1,
    SACC_PGA_X4 = 3'h2,
    SACC_PGA_X8 = 3'h3,
    SACC_PGA_X16 = 3'h4,
    SACC_PGA_X0P5 = 3'h5
  } sacc_pga_t;

  typedef struct packed {
    logic en;
    logic tm;
    sacc_src_t src;
    logic ljst;
  } sacc_ctrl_t;

  typedef struct packed {
    logic hv_amp_enable;
    logic [3:0] hv_amp_gain_code;
    sacc_pga_t pga_gain;
    logic converter_enable;
    logic track;
    logic convert_active;
  } sacc_afe_t;

endpackage

`default_nettype wire

/* File: verif/sacc_core_model.sv */
// Behavioural model of the analog SAR core that faces the control block.
// Assumes the afe_q bundle and the sar clock pulses of sacc_top on ref_clk.
`default_nettype none

module sacc_core_model
  import sacc_pkg::*;
(
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // Controls from the block.
  input wire sacc_pkg::sacc_afe_t afe,
  input wire logic sar_clock,
  // Value that the bench wants converted.
  input wire logic [11:0] res_val,
  input wire logic diff_val,
  // Towards the block and the bench.
  output logic [11:0] sar_result,
  output logic sar_differential,
  output var int ticks
);
  timeunit 1ns;
  timeprecision 1ps;

  // Outside a conversion the lines carry the inverse, so a mistimed capture shows.
  assign sar_result = afe.convert_active ? res_val : ~res_val;
  assign sar_differential = afe.convert_active ? diff_val : ~diff_val;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ticks <= 0;
    end else if (sar_clock) begin
      ticks <= ticks + 1;
    end
  end
endmodule

`default_nettype wire

/* File: verif/sacc_top_tb.sv */
// Self-checking bench for the converter control block.
// Assumes sacc_top as the design and sacc_core_model as the analog core.
`include "sacc_map.svh"
`default_nettype none

module sacc_top_tb;
  import sacc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] bus_addr = 8'h00;
  logic [7:0] bus_wdata = 8'h00;
  logic bus_we = 1'b0;
  logic bus_re = 1'b0;
  logic [7:0] bus_rdata_q;
  logic timer2_overflow = 1'b0;
  logic timer3_overflow = 1'b0;
  logic ext_convert_start = 1'b0;
  logic chip_standby = 1'b0;
  logic window_match = 1'b0;
  logic [11:0] sar_result;
  logic sar_differential;
  sacc_afe_t afe_q;
  logic sar_clock_q;
  logic conversion_done_pulse_q;
  logic [11:0] res_val = 12'h000;
  logic diff_val = 1'b0;
  int ticks;
  int bad_count = 0;
  int num_checks = 0;
  int cyc = 0;

  sacc_top u_dut (
    .ref_clk(ref_clk), .rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_we(bus_we), .bus_re(bus_re), .bus_rdata_q(bus_rdata_q),
    .timer2_overflow(timer2_overflow), .timer3_overflow(timer3_overflow),
    .ext_convert_start(ext_convert_start), .chip_standby(chip_standby),
    .window_match(window_match), .sar_result(sar_result),
    .sar_differential(sar_differential), .afe_q(afe_q), .sar_clock_q(sar_clock_q),
    .conversion_done_pulse_q(conversion_done_pulse_q)
  );

  sacc_core_model u_core (
    .ref_clk(ref_clk), .rst(rst), .afe(afe_q), .sar_clock(sar_clock_q),
    .res_val(res_val), .diff_val(diff_val), .sar_result(sar_result),
    .sar_differential(sar_differential), .ticks(ticks)
  );

  always #25 ref_clk = ~ref_clk;

  // The whole run needs about two thousand cycles; the ceiling leaves margin.
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 6000) begin
      bad_count++;
      results();
    end
  end

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      bad_count++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_we <= 1'b1;
    @(posedge ref_clk);
    bus_we <= 1'b0;
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    bus_addr <= a;
    bus_re <= 1'b1;
    @(posedge ref_clk);
    bus_re <= 1'b0;
    #1;
    chk(what, exp, bus_rdata_q);
  endtask

  // Source 1 pulses timer three, 3 pulses timer two, 2 raises the pin.
  task automatic tick(input int src);
    @(posedge ref_clk);
    timer3_overflow <= (src == 1);
    timer2_overflow <= (src == 3);
    ext_convert_start <= (src == 2);
    @(posedge ref_clk);
    timer3_overflow <= 1'b0;
    timer2_overflow <= 1'b0;
  endtask

  task automatic conv(input logic [4:0] dv, input logic [7:0] ctl, input int src,
                      input logic [11:0] r, input logic d);
    int n;
    int t0;
    int span;
    logic [3:0] sx;
    span = (ctl[6] && src != 2) ? 17 : 14;
    sx = {4{d & r[11]}};
    // Starts stay at least ten microseconds apart.
    repeat (200) @(posedge ref_clk);
    @(posedge ref_clk);
    res_val <= r;
    diff_val <= d;
    wr(`SACC_ADDR_CFG, {dv, 3'h0});
    t0 = ticks;
    wr(`SACC_ADDR_CTRL, ctl | 8'h10);
    if (src != 0) begin
      tick(src == 1 ? 3 : 1);
      rd_chk("no start", `SACC_ADDR_CTRL, ctl);
      if (src == 2) chk("track pin low", 1, afe_q.track);
      tick(src);
    end
    n = 0;
    // A second timer trigger while busy must leave the length unchanged.
    while (conversion_done_pulse_q !== 1'b1 && n < 2000) begin
      @(posedge ref_clk);
      timer3_overflow <= (src == 1 && n == 4);
      timer2_overflow <= (src == 3 && n == 4);
      #1;
      n++;
    end
    if (src == 2) begin
      chk("ext span", 1, n >= span * (dv + 1) + 1 && n <= span * (dv + 1) + 6);
    end else begin
      chk("span", span * (dv + 1), n);
    end
    @(posedge ref_clk);
    #1;
    chk("pulse once", 0, conversion_done_pulse_q);
    // The model counts the last SAR clock one edge after the done pulse.
    chk("sar clocks", span, ticks - t0);
    rd_chk("ctrl done", `SACC_ADDR_CTRL, (ctl & 8'hcd) | 8'h20);
    rd_chk("res hi", `SACC_ADDR_RES_HI, ctl[0] ? r[11:4] : {sx, r[11:8]});
    rd_chk("res lo", `SACC_ADDR_RES_LO, ctl[0] ? {r[3:0], 4'h0} : r[7:0]);
    @(posedge ref_clk);
    ext_convert_start <= 1'b0;
  endtask

  initial begin
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    rd_chk("cfg reset", `SACC_ADDR_CFG, `SACC_CFG_RST);
    rd_chk("amp reset", `SACC_ADDR_HVA, `SACC_HVA_RST);
    rd_chk("ctrl reset", `SACC_ADDR_CTRL, `SACC_CTRL_RST);
    rd_chk("unmapped", 8'h55, 8'h00);
    for (int g = 0; g < 16; g++) begin
      wr(`SACC_ADDR_HVA, {g[0], 3'h7, g[3:0]});
      @(posedge ref_clk);
      #1;
      chk("amp out", {g[0], g[3:0]}, {afe_q.hv_amp_enable, afe_q.hv_amp_gain_code});
    end
    rd_chk("amp reserved", `SACC_ADDR_HVA, 8'h8f);
    for (int p = 0; p < 8; p++) begin
      wr(`SACC_ADDR_CFG, {5'h1f, p[2:0]});
      @(posedge ref_clk);
      #1;
      chk("pga", (p < 4) ? p : ((p < 6) ? 4 : 5), afe_q.pga_gain);
    end
    wr(`SACC_ADDR_CTRL, 8'h10);
    repeat (3) @(posedge ref_clk);
    rd_chk("off no start", `SACC_ADDR_CTRL, 8'h00);
    wr(`SACC_ADDR_CTRL, 8'h80);
    @(posedge ref_clk);
    #1;
    chk("enable out", 1, afe_q.converter_enable);
    chk("track idle", 1, afe_q.track);
    @(posedge ref_clk);
    chip_standby <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    chk("standby", 0, afe_q.track);
    @(posedge ref_clk);
    chip_standby <= 1'b0;
    conv(5'h0, 8'h80, 0, 12'h5a3, 1'b0);
    conv(5'h2, 8'h85, 1, 12'h9c4, 1'b1);
    conv(5'h1, 8'h8c, 3, 12'h8f1, 1'b1);
    conv(5'h0, 8'hc0, 0, 12'h3e7, 1'b0);
    conv(5'h1, 8'hc4, 1, 12'hc3d, 1'b0);
    conv(5'h1, 8'h88, 2, 12'h7b2, 1'b1);
    conv(5'h1, 8'hc9, 2, 12'hf0e, 1'b1);
    repeat (30) @(posedge ref_clk);
    rd_chk("done held", `SACC_ADDR_CTRL, 8'he9);
    @(posedge ref_clk);
    window_match <= 1'b1;
    @(posedge ref_clk);
    window_match <= 1'b0;
    rd_chk("win set", `SACC_ADDR_CTRL, 8'heb);
    rd_chk("win held", `SACC_ADDR_CTRL, 8'heb);
    wr(`SACC_ADDR_CTRL, 8'hcb);
    rd_chk("done clear", `SACC_ADDR_CTRL, 8'hcb);
    wr(`SACC_ADDR_CTRL, 8'he9);
    rd_chk("win clear", `SACC_ADDR_CTRL, 8'hc9);
    results();
  end
endmodule

`default_nettype wire
